// file: verilog/psm_pkg.sv
// Purpose: constants shared by the port 2 / port 3 pin-sharing block
// Assumes: AXI4-Lite register access, 32-bit data, one clock (sys_clk)
// Notes: register map, field positions and reset values live here only
//
// Functional notes
// - converter trigger pin stays input while converting unless the trigger drive bit is set
// - clock monitor on its pin only when enabled
// - port3 bits 2-5 are GPIO unless compare enabled
// - compare events 0-3 drive port3 bits 2-5
// - pulse generator waves on bits 6,7 per enable
// - port3 bits 6,7 are GPIO unless wave enabled

package psm_pkg;

	// register byte offsets
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_P3DATA = 8'h04;
	localparam logic [7:0] ADDR_P3DIR  = 8'h08;
	localparam logic [7:0] ADDR_P2CTL  = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;

	// register indices returned by the decoder
	localparam logic [2:0] IDX_CTRL   = 3'h0;
	localparam logic [2:0] IDX_P3DATA = 3'h1;
	localparam logic [2:0] IDX_P3DIR  = 3'h2;
	localparam logic [2:0] IDX_P2CTL  = 3'h3;
	localparam logic [2:0] IDX_STATUS = 3'h4;
	localparam logic [2:0] IDX_NONE   = 3'h7;

	// control register fields
	localparam int CTRL_CLKMON_OE  = 0;
	localparam int CTRL_TRIG_DRIVE = 1;
	localparam int CTRL_CMP_LSB    = 2;
	localparam int CTRL_PGA_OE     = 6;
	localparam int CTRL_PGB_OE     = 7;

	// port 2 control fields
	localparam int P2_DATA = 0;
	localparam int P2_DIR  = 1;

	// status fields
	localparam int STAT_P2_IN  = 8;
	localparam int STAT_CONV   = 9;

	// port 3 bit positions of the shared functions
	localparam int P3_CLKMON = 1;
	localparam int P3_PGA    = 6;
	localparam int P3_PGB    = 7;

	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] PORT_RESET = 8'h00;
	localparam logic [1:0] P2_RESET   = 2'h0;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : psm_pkg

// file: verilog/psm_pin_cell.sv
// Purpose: one shared pin: port data/direction or a peripheral output
// Assumes: all inputs synchronous to sys_clk
// Notes: pin_out and pin_oe come straight from flip-flops

`timescale 1ns/1ps
`default_nettype none

module psm_pin_cell (
	input  wire logic sys_clk,
	input  wire logic rstn,
	input  wire logic port_data,
	input  wire logic port_dir,
	input  wire logic periph_en,
	input  wire logic periph_val,
	output var  logic pin_out,
	output var  logic pin_oe
);

	typedef struct packed {
		logic out;
		logic oe;
	} psm_cell_s;

	psm_cell_s state;
	psm_cell_s next_state;

	// peripheral takes the pin over while enabled; port returns one clock after clear
	always_comb begin
		next_state = state;
		if (periph_en) begin
			next_state.out = periph_val;
			next_state.oe  = 1'b1;
		end else begin
			next_state.out = port_data;
			next_state.oe  = port_dir;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign pin_out = state.out;
	assign pin_oe  = state.oe;

endmodule : psm_pin_cell

`default_nettype wire

// file: verilog/psm_pin_mux.sv
// Purpose: pin sharing for port2 bit7 and port3 bits 0-7 with AXI4-Lite registers
// Assumes: peripheral signals and pin inputs synchronous to sys_clk (25 MHz)
// Notes: one write and one read in flight; answers one cycle after acceptance

`timescale 1ns/1ps
`default_nettype none

module psm_pin_mux (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// peripheral side
	input  wire logic        converter_active,
	output var  logic        converter_trigger_in,
	input  wire logic        clkmon_signal,
	input  wire logic        compare_event_ch0,
	input  wire logic        compare_event_ch1,
	input  wire logic        compare_event_ch2,
	input  wire logic        compare_event_ch3,
	input  wire logic        pulse_gen0_wave_a,
	input  wire logic        pulse_gen0_wave_b,
	// pins
	input  wire logic        port2_bit7_in,
	output var  logic        port2_bit7_out,
	output var  logic        port2_bit7_oe,
	input  wire logic [7:0]  port3_in,
	output var  logic [7:0]  port3_out,
	output var  logic [7:0]  port3_oe
);

	typedef struct packed {
		logic        awready;
		logic        aw_held;
		logic [7:0]  awaddr;
		logic        wready;
		logic        w_held;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [7:0]  ctrl;
		logic [7:0]  p3_data;
		logic [7:0]  p3_dir;
		logic [1:0]  p2_ctl;
		logic        trig;
	} psm_state_s;

	psm_state_s state;
	psm_state_s next_state;

	logic [7:0] periph_en;
	logic [7:0] periph_val;
	logic       p2_dir_eff;

	// maps a byte address onto a register index; used by both read and write paths
	function automatic logic [2:0] psm_decode(input logic [7:0] addr);
		case (addr)
			psm_pkg::ADDR_CTRL:   psm_decode = psm_pkg::IDX_CTRL;
			psm_pkg::ADDR_P3DATA: psm_decode = psm_pkg::IDX_P3DATA;
			psm_pkg::ADDR_P3DIR:  psm_decode = psm_pkg::IDX_P3DIR;
			psm_pkg::ADDR_P2CTL:  psm_decode = psm_pkg::IDX_P2CTL;
			psm_pkg::ADDR_STATUS: psm_decode = psm_pkg::IDX_STATUS;
			default:              psm_decode = psm_pkg::IDX_NONE;
		endcase
	endfunction : psm_decode

	// byte-lane merge of write data into an old register value
	function automatic logic [31:0] psm_merge(input logic [31:0] old,
	                                          input logic [31:0] data,
	                                          input logic [3:0]  strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction : psm_merge

	// register read image; status shows live pin levels and converter state
	function automatic logic [31:0] psm_read(input logic [2:0] idx, input psm_state_s s);
		logic [31:0] v;
		v = '0;
		case (idx)
			psm_pkg::IDX_CTRL:   v[7:0] = s.ctrl;
			psm_pkg::IDX_P3DATA: v[7:0] = s.p3_data;
			psm_pkg::IDX_P3DIR:  v[7:0] = s.p3_dir;
			psm_pkg::IDX_P2CTL:  v[1:0] = s.p2_ctl;
			psm_pkg::IDX_STATUS: begin
				v[7:0]                  = port3_in;
				v[psm_pkg::STAT_P2_IN]  = port2_bit7_in;
				v[psm_pkg::STAT_CONV]   = converter_active;
			end
			default: v = '0;
		endcase
		return v;
	endfunction : psm_read

	// bus slave and register update
	always_comb begin
		logic [31:0] merged;
		logic [2:0]  widx;
		merged     = '0;
		widx       = psm_pkg::IDX_NONE;
		next_state = state;
		// trigger path is sampled every cycle so the converter never misses an edge
		next_state.trig = port2_bit7_in;
		if (state.awready && s_axi_awvalid) begin
			next_state.aw_held = 1'b1;
			next_state.awaddr  = s_axi_awaddr;
			next_state.awready = 1'b0;
		end
		if (state.wready && s_axi_wvalid) begin
			next_state.w_held = 1'b1;
			next_state.wdata  = s_axi_wdata;
			next_state.wstrb  = s_axi_wstrb;
			next_state.wready = 1'b0;
		end
		if (next_state.aw_held && next_state.w_held && !state.bvalid) begin
			widx               = psm_decode(next_state.awaddr);
			next_state.aw_held = 1'b0;
			next_state.w_held  = 1'b0;
			next_state.bvalid  = 1'b1;
			next_state.bresp   = psm_pkg::RESP_OKAY;
			case (widx)
				psm_pkg::IDX_CTRL: begin
					merged          = psm_merge({24'h000000, state.ctrl},
					                            next_state.wdata, next_state.wstrb);
					next_state.ctrl = merged[7:0];
				end
				psm_pkg::IDX_P3DATA: begin
					merged             = psm_merge({24'h000000, state.p3_data},
					                               next_state.wdata, next_state.wstrb);
					next_state.p3_data = merged[7:0];
				end
				psm_pkg::IDX_P3DIR: begin
					merged            = psm_merge({24'h000000, state.p3_dir},
					                              next_state.wdata, next_state.wstrb);
					next_state.p3_dir = merged[7:0];
				end
				psm_pkg::IDX_P2CTL: begin
					merged            = psm_merge({30'h00000000, state.p2_ctl},
					                              next_state.wdata, next_state.wstrb);
					next_state.p2_ctl = merged[1:0];
				end
				psm_pkg::IDX_STATUS: next_state.bresp = psm_pkg::RESP_OKAY; // read-only, write ignored
				default: next_state.bresp = psm_pkg::RESP_SLVERR;
			endcase
		end
		if (state.bvalid && s_axi_bready) begin
			next_state.bvalid  = 1'b0;
			next_state.awready = 1'b1;
			next_state.wready  = 1'b1;
		end
		// read: answer one cycle after the address is taken
		if (state.arready && s_axi_arvalid) begin
			next_state.rdata   = psm_read(psm_decode(s_axi_araddr), state);
			next_state.rresp   = (psm_decode(s_axi_araddr) == psm_pkg::IDX_NONE) ?
			                     psm_pkg::RESP_SLVERR : psm_pkg::RESP_OKAY;
			next_state.rvalid  = 1'b1;
			next_state.arready = 1'b0;
		end
		if (state.rvalid && s_axi_rready) begin
			next_state.rvalid  = 1'b0;
			next_state.arready = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			state         <= '0;
			state.awready <= 1'b1;
			state.wready  <= 1'b1;
			state.arready <= 1'b1;
			state.ctrl    <= psm_pkg::CTRL_RESET;
			state.p3_data <= psm_pkg::PORT_RESET;
			state.p3_dir  <= psm_pkg::PORT_RESET;
			state.p2_ctl  <= psm_pkg::P2_RESET;
		end else begin
			state <= next_state;
		end
	end

	// peripheral ownership of each port3 bit; bit 0 is never shared
	always_comb begin
		periph_en  = '0;
		periph_val = '0;
		periph_en[psm_pkg::P3_CLKMON]  = state.ctrl[psm_pkg::CTRL_CLKMON_OE];
		periph_val[psm_pkg::P3_CLKMON] = clkmon_signal;
		periph_en[psm_pkg::CTRL_CMP_LSB +: 4]  =
			state.ctrl[psm_pkg::CTRL_CMP_LSB +: 4];
		periph_val[psm_pkg::CTRL_CMP_LSB +: 4] = {compare_event_ch3, compare_event_ch2,
		                                          compare_event_ch1, compare_event_ch0};
		periph_en[psm_pkg::P3_PGA]  = state.ctrl[psm_pkg::CTRL_PGA_OE];
		periph_val[psm_pkg::P3_PGA] = pulse_gen0_wave_a;
		periph_en[psm_pkg::P3_PGB]  = state.ctrl[psm_pkg::CTRL_PGB_OE];
		periph_val[psm_pkg::P3_PGB] = pulse_gen0_wave_b;
	end

	// port2 bit7 output is held off while converting unless software forces it
	assign p2_dir_eff = state.p2_ctl[psm_pkg::P2_DIR] &
	                    (~converter_active | state.ctrl[psm_pkg::CTRL_TRIG_DRIVE]);

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_p3
			psm_pin_cell u_cell (
				.sys_clk    (sys_clk),
				.rstn       (rstn),
				.port_data  (state.p3_data[g]),
				.port_dir   (state.p3_dir[g]),
				.periph_en  (periph_en[g]),
				.periph_val (periph_val[g]),
				.pin_out    (port3_out[g]),
				.pin_oe     (port3_oe[g])
			);
		end
	endgenerate

	psm_pin_cell u_p2 (
		.sys_clk    (sys_clk),
		.rstn       (rstn),
		.port_data  (state.p2_ctl[psm_pkg::P2_DATA]),
		.port_dir   (p2_dir_eff),
		.periph_en  (1'b0),
		.periph_val (1'b0),
		.pin_out    (port2_bit7_out),
		.pin_oe     (port2_bit7_oe)
	);

	assign s_axi_awready        = state.awready;
	assign s_axi_wready         = state.wready;
	assign s_axi_bvalid         = state.bvalid;
	assign s_axi_bresp          = state.bresp;
	assign s_axi_arready        = state.arready;
	assign s_axi_rvalid         = state.rvalid;
	assign s_axi_rdata          = state.rdata;
	assign s_axi_rresp          = state.rresp;
	assign converter_trigger_in = state.trig;

endmodule : psm_pin_mux

`default_nettype wire

// file: tb/psm_props.sv
// Purpose: port-level checks of psm_pin_mux
// Assumes: write address and data are taken on one edge
// Notes: shadows ctrl, data and dir; byte strobes are not modelled
`timescale 1ns/1ps
`default_nettype none
module psm_props (
	input wire logic        sys_clk,
	input wire logic        rstn,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        converter_active,
	input wire logic        converter_trigger_in,
	input wire logic        clkmon_signal,
	input wire logic        compare_event_ch0,
	input wire logic        compare_event_ch1,
	input wire logic        compare_event_ch2,
	input wire logic        compare_event_ch3,
	input wire logic        pulse_gen0_wave_a,
	input wire logic        pulse_gen0_wave_b,
	input wire logic        port2_bit7_in,
	input wire logic        port2_bit7_oe,
	input wire logic [7:0]  port3_out,
	input wire logic [7:0]  port3_oe
);
	logic [7:0] ctl, dat, dir, en, pv;
	// shadow registers, updated on the same edge as the design's own
	always_ff @(posedge sys_clk)
		if (!rstn) {ctl, dat, dir} <= '0;
		else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
			case (s_axi_awaddr)
			psm_pkg::ADDR_CTRL: ctl <= s_axi_wdata[7:0];
			psm_pkg::ADDR_P3DATA: dat <= s_axi_wdata[7:0];
			psm_pkg::ADDR_P3DIR: dir <= s_axi_wdata[7:0];
			default: ;
			endcase
	// per-pin peripheral enable and value; bit0 has no peripheral
	assign en = {ctl[7:2], ctl[0], 1'b0};
	assign pv = {pulse_gen0_wave_b, pulse_gen0_wave_a, compare_event_ch3, compare_event_ch2,
		compare_event_ch1, compare_event_ch0, clkmon_signal, 1'b0};
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_wr_wait;
		s_axi_bvalid && !s_axi_awready && !s_axi_wready;
	endsequence
	chk_trig_follow: assert property ($past(rstn) |-> converter_trigger_in == $past(port2_bit7_in))
		else $error("trigger not one clock behind pin");
	chk_conv_input: assert property (rstn && converter_active && !ctl[1] |=> !port2_bit7_oe)
		else $error("trigger pin driven while converting");
	chk_periph_drive: assert property (rstn |=> ((port3_out ^ $past(pv)) & $past(en)) == 8'h00
		&& (port3_oe & $past(en)) == $past(en)) else $error("peripheral not on its pin");
	chk_gpio_hold: assert property (rstn |=> ((port3_out ^ $past(dat)) & ~$past(en)) == 8'h00
		&& ((port3_oe ^ $past(dir)) & ~$past(en)) == 8'h00) else $error("port control lost");
	chk_wr_answer: assert property (s_wr_take |=> s_wr_wait)
		else $error("no write response");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	chk_ready_back: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
		else $error("write channel not reopened");
	chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("no read response");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	chk_rd_err: assert property (s_axi_rvalid && s_axi_rresp == psm_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("error read carries data");
endmodule : psm_props
bind psm_pin_mux psm_props i_props (.*);
`default_nettype wire

// file: tb/psm_board.sv
// Purpose: board circuitry on the shared pins
// Assumes: the bench says which pins the board drives
// Notes: a floating pin flips every clock so no stale level survives
`timescale 1ns/1ps
`default_nettype none
module psm_board (
	input wire logic       sys_clk,
	input wire logic [7:0] port3_out,
	input wire logic [7:0] port3_oe,
	input wire logic       port2_bit7_out,
	input wire logic       port2_bit7_oe,
	input wire logic [8:0] ext_val,
	input wire logic [8:0] ext_en,
	output var logic [7:0] port3_in,
	output var logic       port2_bit7_in
);
	logic [8:0] fl = 9'h000;
	logic [8:0] oe;
	// floating pattern
	always_ff @(posedge sys_clk) fl <= ~fl;
	// the board yields to the device, so the trigger line never sees a clash
	assign oe = {port2_bit7_oe, port3_oe};
	assign {port2_bit7_in, port3_in} = (oe & {port2_bit7_out, port3_out})
		| (~oe & ((ext_en & ext_val) | (~ext_en & fl)));
endmodule : psm_board
`default_nettype wire

// file: tb/test_psm_pin_mux.sv
// Purpose: self-checking bench of psm_pin_mux
// Assumes: registers as in psm_pkg
// Notes: each scenario is one task
`timescale 1ns/1ps
`default_nettype none
module test_psm_pin_mux;
	logic        sys_clk = 1'b0, rstn = 1'b0, converter_active = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, pv = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        clkmon_signal, compare_event_ch0, compare_event_ch1, compare_event_ch2;
	logic        compare_event_ch3, pulse_gen0_wave_a, pulse_gen0_wave_b;
	logic        converter_trigger_in, port2_bit7_in, port2_bit7_out, port2_bit7_oe;
	logic [7:0]  port3_in, port3_out, port3_oe, m;
	logic [8:0]  ext_val = 9'h100, ext_en = 9'h100;
	int          err_count = 0, n_compared = 0;
	assign {pulse_gen0_wave_b, pulse_gen0_wave_a, compare_event_ch3, compare_event_ch2,
		compare_event_ch1, compare_event_ch0, clkmon_signal} = pv[7:1];
	psm_pin_mux i_dut (.*);
	psm_board i_board (.*);
	initial forever #20 sys_clk = ~sys_clk;
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check
	task finish_test;
		if (err_count == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : finish_test
	// master holds each channel until its ready edge; the response closes it
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge sys_clk);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (++n > 40) begin
				err_count++;
				finish_test();
			end
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		check(s_axi_bresp, er);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (++n > 40) begin
				err_count++;
				finish_test();
			end
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		check(s_axi_rdata, ed);
		check(s_axi_rresp, er);
	endtask : rd
	// pins settle one edge after the register or input change; the check waits two edges
	task pins(input logic [7:0] eo, input logic [7:0] ee);
		repeat (2) @(posedge sys_clk);
		#1;
		check(port3_out, eo);
		check(port3_oe, ee);
	endtask : pins
	task t_reset;
		for (int a = 0; a < 16; a += 4) rd(a[7:0], 32'h0, psm_pkg::RESP_OKAY);
		pins(8'h00, 8'h00);
		check(port2_bit7_oe, 1'b0);
	endtask : t_reset
	task t_gpio;
		wr(psm_pkg::ADDR_P3DIR, 32'hff, psm_pkg::RESP_OKAY);
		wr(psm_pkg::ADDR_P3DATA, 32'ha5, psm_pkg::RESP_OKAY);
		pins(8'ha5, 8'hff);
		rd(psm_pkg::ADDR_STATUS, 32'h1a5, psm_pkg::RESP_OKAY);
	endtask : t_gpio
	// each enable alone, then all at once, then released back to the port
	task t_periph;
		wr(psm_pkg::ADDR_P3DIR, 32'h00, psm_pkg::RESP_OKAY);
		wr(psm_pkg::ADDR_P3DATA, 32'hff, psm_pkg::RESP_OKAY);
		for (int i = 0; i < 8; i++) if (i != 1) begin
			m = (i == 0) ? 8'h02 : 8'h01 << i;
			wr(psm_pkg::ADDR_CTRL, 32'h1 << i, psm_pkg::RESP_OKAY);
			pv <= 8'h00;
			pins(~m, m);
			pv <= 8'hff;
			pins(8'hff, m);
		end
		wr(psm_pkg::ADDR_CTRL, 32'hfd, psm_pkg::RESP_OKAY);
		pv <= 8'haa;
		pins(8'hab, 8'hfe);
		wr(psm_pkg::ADDR_CTRL, 32'h00, psm_pkg::RESP_OKAY);
		pins(8'hff, 8'h00);
	endtask : t_periph
	task t_conv;
		ext_en <= 9'h1ff;
		ext_val <= 9'h0c3;
		converter_active <= 1'b1;
		wr(psm_pkg::ADDR_P2CTL, 32'h3, psm_pkg::RESP_OKAY);
		pins(8'hff, 8'h00);
		check(port2_bit7_oe, 1'b0);
		check(converter_trigger_in, 1'b0);
		rd(psm_pkg::ADDR_STATUS, 32'h2c3, psm_pkg::RESP_OKAY);
		ext_val <= 9'h1c3;
		pins(8'hff, 8'h00);
		check(converter_trigger_in, 1'b1);
		wr(psm_pkg::ADDR_CTRL, 32'h02, psm_pkg::RESP_OKAY);
		pins(8'hff, 8'h00);
		check({port2_bit7_oe, port2_bit7_out}, 2'h3);
		converter_active <= 1'b0;
	endtask : t_conv
	task t_err;
		rd(8'h14, 32'h0, psm_pkg::RESP_SLVERR);
		wr(8'h14, 32'hffffffff, psm_pkg::RESP_SLVERR);
		wr(psm_pkg::ADDR_STATUS, 32'hff, psm_pkg::RESP_OKAY);
		rd(psm_pkg::ADDR_CTRL, 32'h02, psm_pkg::RESP_OKAY);
	endtask : t_err
	initial begin
		repeat (8) @(posedge sys_clk);
		rstn <= 1'b1;
		t_reset();
		t_gpio();
		t_periph();
		t_conv();
		t_err();
		finish_test();
	end
endmodule : test_psm_pin_mux
`default_nettype wire
